// ### bst_tap.sv
// bst_tap.sv: boundary-scan test access port, pins sampled on sys_clk_i
// assumes tck is far slower than sys_clk_i; trst_n_i is asynchronous
// Notes on behaviour
// - tms and tdi captured on tck rise
// - state follows tms every tck rise
// - tdo changes only on tck fall
// - tdo floats outside both shift states
// - tdi ignored outside both shift states
// - shift states move bits toward tdo
// - all-ones instruction selects bypass
// - stopped tck leaves shift, bypass and update registers unchanged
// - trst and power-up force test-logic-reset
// - five tms highs reach test-logic-reset
// - test logic disabled in test-logic-reset
// - reset state loads idcode instruction
`timescale 1ns/10ps
`default_nettype none
`include "bst_consts.svh"
module bst_tap
  import bst_pkg::*;
#(
  parameter int IR_W  = `BST_IR_WIDTH,
  parameter int BSR_W = 8
) (
  input  wire logic             sys_clk_i,
  input  wire logic             srst_i,
  input  wire logic             tck_i,
  input  wire logic             tms_i,
  input  wire logic             tdi_i,
  input  wire logic             trst_n_i,
  input  wire logic [BSR_W-1:0] bsr_capture_i,
  output logic                  tdo_o,
  output logic                  tdo_oe_o,
  output logic                  test_mode_o,
  output logic      [BSR_W-1:0] bsr_update_o,
  output logic      [IR_W-1:0]  ir_o
);
  localparam logic [IR_W-1:0] IR_BYP = `BST_IR_BYPASS;
  localparam logic [IR_W-1:0] IR_ID  = `BST_IR_IDCODE;
  localparam logic [IR_W-1:0] IR_EXT = `BST_IR_EXTEST;

  logic [2:0] pins_s;
  logic       tck_s;
  logic       tms_s;
  logic       tdi_s;
  logic       trst_n_s;

  bst_sync #(.WIDTH(3)) u_sync (
    .sys_clk_i (sys_clk_i),
    .srst_i    (srst_i),
    .pin_i     ({tck_i, tms_i, tdi_i}),
    .sync_o    (pins_s)
  );
  assign tck_s = pins_s[2];
  assign tms_s = pins_s[1];
  assign tdi_s = pins_s[0];

  // trst gets its own pair, reset to asserted so power-up sits in reset
  logic trst_meta_ff;
  logic trst_sync_ff;
  always_ff @(posedge sys_clk_i) begin
    if (srst_i) begin
      trst_meta_ff <= 1'b0;
      trst_sync_ff <= 1'b0;
    end else begin
      trst_meta_ff <= trst_n_i;
      trst_sync_ff <= trst_meta_ff;
    end
  end
  assign trst_n_s = trst_sync_ff;

  logic tck_d_ff;
  logic rise;
  logic fall;
  assign rise = tck_s & ~tck_d_ff;
  assign fall = ~tck_s & tck_d_ff;

  bst_state_t          state_ff, nxt_state;
  logic [IR_W-1:0]     ir_sh_ff, nxt_ir_sh;
  logic [IR_W-1:0]     ir_ff, nxt_ir;
  logic [31:0]         id_sh_ff, nxt_id_sh;
  logic                byp_ff, nxt_byp;
  logic [BSR_W-1:0]    bsr_sh_ff, nxt_bsr_sh;
  logic [BSR_W-1:0]    bsr_up_ff, nxt_bsr_up;
  logic                tdo_ff, nxt_tdo;
  logic                oe_ff, nxt_oe;
  logic                shifting;
  logic                dr_out;

  assign shifting = (state_ff == BST_SHIR) || (state_ff == BST_SHDR);

  always_comb begin
    case (ir_ff)
      IR_BYP:  dr_out = byp_ff;
      IR_ID:   dr_out = id_sh_ff[0];
      default: dr_out = bsr_sh_ff[0];
    endcase
  end

  always_comb begin
    nxt_state = state_ff;
    if (rise) begin
      case (state_ff)
        BST_TLR:   nxt_state = tms_s ? BST_TLR   : BST_RTI;
        BST_RTI:   nxt_state = tms_s ? BST_SELDR : BST_RTI;
        BST_SELDR: nxt_state = tms_s ? BST_SELIR : BST_CAPDR;
        BST_CAPDR: nxt_state = tms_s ? BST_EX1DR : BST_SHDR;
        BST_SHDR:  nxt_state = tms_s ? BST_EX1DR : BST_SHDR;
        BST_EX1DR: nxt_state = tms_s ? BST_UPDR  : BST_PADR;
        BST_PADR:  nxt_state = tms_s ? BST_EX2DR : BST_PADR;
        BST_EX2DR: nxt_state = tms_s ? BST_UPDR  : BST_SHDR;
        BST_UPDR:  nxt_state = tms_s ? BST_SELDR : BST_RTI;
        BST_SELIR: nxt_state = tms_s ? BST_TLR   : BST_CAPIR;
        BST_CAPIR: nxt_state = tms_s ? BST_EX1IR : BST_SHIR;
        BST_SHIR:  nxt_state = tms_s ? BST_EX1IR : BST_SHIR;
        BST_EX1IR: nxt_state = tms_s ? BST_UPIR  : BST_PAIR;
        BST_PAIR:  nxt_state = tms_s ? BST_EX2IR : BST_PAIR;
        BST_EX2IR: nxt_state = tms_s ? BST_UPIR  : BST_SHIR;
        BST_UPIR:  nxt_state = tms_s ? BST_SELDR : BST_RTI;
        default:   nxt_state = BST_TLR;
      endcase
    end
    if (!trst_n_s) begin
      nxt_state = BST_TLR;
    end
  end

  always_comb begin
    nxt_ir_sh  = ir_sh_ff;
    nxt_ir     = ir_ff;
    nxt_id_sh  = id_sh_ff;
    nxt_byp    = byp_ff;
    nxt_bsr_sh = bsr_sh_ff;
    nxt_bsr_up = bsr_up_ff;
    nxt_tdo    = tdo_ff;
    nxt_oe     = oe_ff;
    if (state_ff == BST_TLR) begin
      nxt_ir = IR_ID;
    end
    // shift, update and tdo registers move on a tck edge, except that trst and the reset state load ir_ff and trst clears oe_ff
    if (rise) begin
      case (state_ff)
        BST_CAPIR: nxt_ir_sh = IR_W'(`BST_IR_CAPTURE);
        BST_SHIR:  nxt_ir_sh = {tdi_s, ir_sh_ff[IR_W-1:1]};
        BST_UPIR:  nxt_ir = ir_sh_ff;
        BST_CAPDR: begin
          nxt_byp    = 1'b0;
          nxt_id_sh  = `BST_IDCODE_RESET;
          nxt_bsr_sh = bsr_capture_i;
        end
        BST_SHDR: begin
          case (ir_ff)
            IR_BYP:  nxt_byp = tdi_s;
            IR_ID:   nxt_id_sh = {tdi_s, id_sh_ff[31:1]};
            default: nxt_bsr_sh = {tdi_s, bsr_sh_ff[BSR_W-1:1]};
          endcase
        end
        BST_UPDR:  nxt_bsr_up = bsr_sh_ff;
        default:   nxt_ir_sh = ir_sh_ff;
      endcase
    end
    if (fall) begin
      nxt_oe  = shifting;
      nxt_tdo = (state_ff == BST_SHIR) ? ir_sh_ff[0] : dr_out;
    end
    if (!trst_n_s) begin
      nxt_ir = IR_ID;
      nxt_oe = 1'b0;
    end
  end

  always_ff @(posedge sys_clk_i) begin
    if (srst_i) begin
      tck_d_ff  <= 1'b0;
      state_ff  <= BST_TLR;
      ir_sh_ff  <= '0;
      ir_ff     <= IR_ID;
      id_sh_ff  <= '0;
      byp_ff    <= 1'b0;
      bsr_sh_ff <= '0;
      bsr_up_ff <= '0;
      tdo_ff    <= 1'b0;
      oe_ff     <= 1'b0;
    end else begin
      tck_d_ff  <= tck_s;
      state_ff  <= nxt_state;
      ir_sh_ff  <= nxt_ir_sh;
      ir_ff     <= nxt_ir;
      id_sh_ff  <= nxt_id_sh;
      byp_ff    <= nxt_byp;
      bsr_sh_ff <= nxt_bsr_sh;
      bsr_up_ff <= nxt_bsr_up;
      tdo_ff    <= nxt_tdo;
      oe_ff     <= nxt_oe;
    end
  end

  assign tdo_o        = tdo_ff;
  assign tdo_oe_o     = oe_ff;
  assign test_mode_o  = (state_ff != BST_TLR) && (ir_ff == IR_EXT);
  assign bsr_update_o = bsr_up_ff;
  assign ir_o         = ir_ff;

  // helper: tms-high run length counted on tck rises
  logic [2:0] ones_cnt_ff;
  always_ff @(posedge sys_clk_i) begin
    if (srst_i) begin
      ones_cnt_ff <= '0;
    end else if (rise) begin
      ones_cnt_ff <= tms_s ? ((ones_cnt_ff == 3'h7) ? ones_cnt_ff : ones_cnt_ff + 3'h1) : 3'h0;
    end
  end

  a_five_ones_tlr: assert property (
    @(posedge sys_clk_i) disable iff (srst_i)
    (ones_cnt_ff >= 3'(`BST_RESET_ONES)) |-> (state_ff == BST_TLR))
    else $error("five tms highs did not reach reset state");
  a_tdo_fall_only: assert property (
    @(posedge sys_clk_i) disable iff (srst_i)
    !$past(fall) |-> $stable(tdo_o))
    else $error("tdo changed away from a tck fall");
  a_oe_shift_only: assert property (
    @(posedge sys_clk_i) disable iff (srst_i)
    (fall && trst_n_s) |=> (tdo_oe_o == $past(shifting)))
    else $error("tdo driven outside shift states");
  a_state_no_rise: assert property (
    @(posedge sys_clk_i) disable iff (srst_i)
    (!$past(rise) && $past(trst_n_s)) |-> $stable(state_ff))
    else $error("state moved without a tck rise");
  a_storage_hold: assert property (
    @(posedge sys_clk_i) disable iff (srst_i)
    (!$past(rise) && !tck_s) |-> ($stable(ir_sh_ff) && $stable(bsr_sh_ff) && $stable(byp_ff)))
    else $error("storage changed while tck held low");
  a_trst_forces: assert property (
    @(posedge sys_clk_i) disable iff (srst_i)
    !trst_n_s |=> (state_ff == BST_TLR) && (ir_ff == IR_ID))
    else $error("trst did not force reset state");
  a_tlr_idcode: assert property (
    @(posedge sys_clk_i) disable iff (srst_i)
    (state_ff == BST_TLR) |=> (ir_ff == IR_ID))
    else $error("idcode not selected in reset state");
  a_ir_shift_in: assert property (
    @(posedge sys_clk_i) disable iff (srst_i)
    (rise && state_ff == BST_SHIR) |=> (ir_sh_ff[IR_W-1] == $past(tdi_s)))
    else $error("ir shift lost the tdi bit");
  a_tdi_ignored: assert property (
    @(posedge sys_clk_i) disable iff (srst_i)
    (rise && state_ff == BST_RTI) |=> $stable(ir_sh_ff) && $stable(byp_ff))
    else $error("tdi affected logic outside shift");
  a_test_off_tlr: assert property (
    @(posedge sys_clk_i) disable iff (srst_i)
    (state_ff == BST_TLR) |-> !test_mode_o)
    else $error("test logic active in reset state");
endmodule
`default_nettype wire

// ### bst_consts.svh
// bst_consts.svh: constants for the boundary-scan tap block
// assumes inclusion by bare name from the tap module and the bench, not from bst_pkg.sv
`ifndef BST_CONSTS_SVH
`define BST_CONSTS_SVH
`define BST_IR_WIDTH      4
`define BST_IR_BYPASS     4'hf
`define BST_IR_IDCODE     4'h1
`define BST_IR_EXTEST     4'h0
`define BST_IR_CAPTURE    4'h1
`define BST_RESET_ONES    5
`define BST_IDCODE_RESET  32'h00000001
`endif

// ### bst_pkg.sv
// bst_pkg.sv: types for the boundary-scan tap block
// assumes bst_consts.svh is on the include path
package bst_pkg;
  typedef enum logic [3:0] {
    BST_TLR   = 4'h0,
    BST_RTI   = 4'h1,
    BST_SELDR = 4'h2,
    BST_CAPDR = 4'h3,
    BST_SHDR  = 4'h4,
    BST_EX1DR = 4'h5,
    BST_PADR  = 4'h6,
    BST_EX2DR = 4'h7,
    BST_UPDR  = 4'h8,
    BST_SELIR = 4'h9,
    BST_CAPIR = 4'ha,
    BST_SHIR  = 4'hb,
    BST_EX1IR = 4'hc,
    BST_PAIR  = 4'hd,
    BST_EX2IR = 4'he,
    BST_UPIR  = 4'hf
  } bst_state_t;
endpackage

// ### bst_sync.sv
// bst_sync.sv: two-flop synchroniser for the test pins, no edge detection
// assumes pins are asynchronous to sys_clk_i
`timescale 1ns/10ps
`default_nettype none
module bst_sync #(
  parameter int WIDTH = 3
) (
  input  wire logic             sys_clk_i,
  input  wire logic             srst_i,
  input  wire logic [WIDTH-1:0] pin_i,
  output logic      [WIDTH-1:0] sync_o
);
  logic [WIDTH-1:0] meta_ff;
  logic [WIDTH-1:0] sync_ff;
  logic [WIDTH-1:0] nxt_meta;
  logic [WIDTH-1:0] nxt_sync;

  always_comb begin
    nxt_meta = pin_i;
    nxt_sync = meta_ff;
  end

  always_ff @(posedge sys_clk_i) begin
    if (srst_i) begin
      meta_ff <= '0;
      sync_ff <= '0;
    end else begin
      meta_ff <= nxt_meta;
      sync_ff <= nxt_sync;
    end
  end

  assign sync_o = sync_ff;
endmodule
`default_nettype wire

// ### bst_ctl_model.sv
// bst_ctl_model.sv: test controller model driving the tap pins
// assumes sys_clk_i is the bench clock; pins change at its falling edge
`timescale 1ns/10ps
`default_nettype none
module bst_ctl_model (
  input  wire logic sys_clk_i,
  input  wire logic tdo_i,
  input  wire logic tdo_oe_i,
  output logic      tck_o,
  output logic      tms_o,
  output logic      tdi_o
);
  initial begin
    tck_o = 1'b0;
    tms_o = 1'b1;
    tdi_o = 1'b1;
  end
  // one 160 ns tck period, tdo taken at the rise
  task automatic step(input logic m, input logic d, output logic q);
    @(negedge sys_clk_i);
    tms_o = m;
    tdi_o = d;
    repeat (7) @(negedge sys_clk_i);
    tck_o = 1'b1;
    q = tdo_oe_i ? tdo_i : 1'bz;
    repeat (8) @(negedge sys_clk_i);
    tck_o = 1'b0;
  endtask
  // idle to idle through one shift state, lsb first
  task automatic scan(input logic ir, input int n, input logic [31:0] din,
                      output logic [31:0] dout);
    logic q;
    dout = '0;
    step(1'b1, 1'b1, q);
    if (ir) step(1'b1, 1'b1, q);
    step(1'b0, 1'b1, q);
    step(1'b0, 1'b1, q);
    for (int i = 0; i < n; i++) begin
      step(i == n - 1, din[i], q);
      dout[i] = q;
    end
    step(1'b1, 1'b1, q);
    step(1'b0, 1'b1, q);
  endtask
endmodule
`default_nettype wire

// ### boundary_scan_tap_pins_test.sv
// boundary_scan_tap_pins_test.sv: self-checking bench for bst_tap
// assumes bst_pkg, bst_consts.svh and bst_ctl_model are compiled first
`timescale 1ns/10ps
`default_nettype none
`include "bst_consts.svh"
module boundary_scan_tap_pins_test;
  logic        sys_clk;
  logic        srst;
  logic        trst_n;
  logic [7:0]  bsr_cap;
  logic        tck;
  logic        tms;
  logic        tdi;
  logic        tdo;
  logic        tdo_oe;
  logic        test_mode;
  logic [7:0]  bsr_upd;
  logic [3:0]  ir;
  logic [31:0] d;
  logic        q;
  int          n_mismatch;
  int          checks;

  bst_tap dut (.sys_clk_i(sys_clk), .srst_i(srst), .tck_i(tck), .tms_i(tms),
    .tdi_i(tdi), .trst_n_i(trst_n), .bsr_capture_i(bsr_cap), .tdo_o(tdo),
    .tdo_oe_o(tdo_oe), .test_mode_o(test_mode), .bsr_update_o(bsr_upd), .ir_o(ir));
  bst_ctl_model ctl (.sys_clk_i(sys_clk), .tdo_i(tdo), .tdo_oe_i(tdo_oe),
    .tck_o(tck), .tms_o(tms), .tdi_o(tdi));

  initial begin
    sys_clk = 1'b0;
    forever #5 sys_clk = ~sys_clk;
  end

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checks++;
    if (got !== exp) begin
      n_mismatch++;
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic close_out();
    $display("checks=%0d mismatches=%0d", checks, n_mismatch);
    if (n_mismatch == 0 && checks > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask

  task automatic t_bypass();
    ctl.scan(1'b1, 4, 32'hf, d);
    chk(32'(d[3:0]), 32'h1);
    chk(32'(ir), 32'hf);
    ctl.scan(1'b0, 3, 32'h5, d);
    chk(32'(d[2:0]), 32'h2);
    chk(32'(tdo_oe), 32'h0);
    $display("done bypass");
  endtask

  task automatic t_five_ones();
    ctl.step(1'b1, 1'b1, q);
    ctl.step(1'b0, 1'b1, q);
    ctl.step(1'b0, 1'b1, q);
    ctl.step(1'b0, 1'b0, q);
    for (int i = 0; i < 5; i++) ctl.step(1'b1, 1'b1, q);
    chk(32'(ir), 32'(`BST_IR_IDCODE));
    chk(32'(tdo_oe), 32'h0);
    ctl.step(1'b0, 1'b1, q);
    ctl.scan(1'b0, 32, 32'h0, d);
    chk(d, `BST_IDCODE_RESET);
    $display("done five ones");
  endtask

  task automatic t_idle_tdi();
    for (int i = 0; i < 4; i++) ctl.step(1'b0, i[0], q);
    chk(32'(ir), 32'(`BST_IR_IDCODE));
    chk(32'(tdo_oe), 32'h0);
    $display("done idle tdi");
  endtask

  task automatic t_extest();
    ctl.scan(1'b1, 4, 32'h0, d);
    chk(32'(test_mode), 32'h1);
    bsr_cap = 8'ha5;
    ctl.scan(1'b0, 8, 32'h3c, d);
    chk(32'(d[7:0]), 32'ha5);
    chk(32'(bsr_upd), 32'h3c);
    bsr_cap = 8'h5a;
    repeat (200) @(negedge sys_clk);
    chk(32'(bsr_upd), 32'h3c);
    chk(32'(ir), 32'h0);
    $display("done extest");
  endtask

  task automatic t_trst();
    @(negedge sys_clk);
    trst_n = 1'b0;
    repeat (6) @(negedge sys_clk);
    chk(32'(ir), 32'(`BST_IR_IDCODE));
    chk(32'(test_mode), 32'h0);
    trst_n = 1'b1;
    repeat (6) @(negedge sys_clk);
    // tap must run again from the reset state
    ctl.step(1'b0, 1'b1, q);
    ctl.scan(1'b0, 32, 32'h0, d);
    chk(d, `BST_IDCODE_RESET);
    chk(32'(tdo_oe), 32'h0);
    $display("done trst");
  endtask

  initial begin
    n_mismatch = 0;
    checks = 0;
    srst = 1'b1;
    trst_n = 1'b1;
    bsr_cap = 8'h00;
    repeat (6) @(negedge sys_clk);
    srst = 1'b0;
    repeat (6) @(negedge sys_clk);
    chk(32'(ir), 32'(`BST_IR_IDCODE));
    chk(32'(test_mode), 32'h0);
    chk(32'(tdo_oe), 32'h0);
    ctl.step(1'b0, 1'b1, q);
    t_bypass();
    t_five_ones();
    t_idle_tdi();
    t_extest();
    t_trst();
    close_out();
  end

  initial begin
    repeat (100000) @(posedge sys_clk);
    n_mismatch++;
    close_out();
  end
endmodule
`default_nettype wire
